/* File: rtl/tgn_consts.svh */
// Register offsets, reset values, field positions and gain constants of the tone generator.
// Assumes it is included by bare name from files under rtl/ and sim/.
`ifndef TGN_CONSTS_SVH
`define TGN_CONSTS_SVH

// Register offsets on the byte-wide control port
`define TGN_OFS_LEFT_CTL 8'h47
`define TGN_OFS_RIGHT_CTL 8'h48
`define TGN_OFS_LEN_HI 8'h49
`define TGN_OFS_LEN_MID 8'h4a
`define TGN_OFS_LEN_LO 8'h4b
`define TGN_OFS_SIN_HI 8'h4c
`define TGN_OFS_SIN_LO 8'h4d
`define TGN_OFS_COS_HI 8'h4e
`define TGN_OFS_COS_LO 8'h4f

// Reset values
`define TGN_RST_LEFT_CTL 8'h00
`define TGN_RST_RIGHT_CTL 8'h00
`define TGN_RST_LEN_HI 8'h00
`define TGN_RST_LEN_MID 8'h00
`define TGN_RST_LEN_LO 8'hee
`define TGN_RST_SIN_HI 8'h10
`define TGN_RST_SIN_LO 8'hd8
`define TGN_RST_COS_HI 8'h7e
`define TGN_RST_COS_LO 8'he3
`define TGN_RST_ZERO8 8'h00

// Field positions
`define TGN_BIT_ENABLE 7
`define TGN_BIT_AUTO_TOUCH 6
`define TGN_VOL_HI 5
`define TGN_VOL_LO 0
`define TGN_LINK_HI 7
`define TGN_LINK_LO 6

// Volume link codes
`define TGN_LINK_LEFT_FROM_RIGHT 2'h1
`define TGN_LINK_RIGHT_FROM_LEFT 2'h2

// Playback processing block mode in which the tone may run
`define TGN_TONE_CAPABLE_PLAYBACK_BLOCK_MODE 5'h19

// Gain: code = 6*q + r; mantissa for r in Q1.14, then shifted right by q
`define TGN_STEPS_PER_OCTAVE 6'h06
`define TGN_GAIN_FRAC 14
`define TGN_GAIN_R0 15'h5092
`define TGN_GAIN_R1 15'h47cf
`define TGN_GAIN_R2 15'h4000
`define TGN_GAIN_R3 15'h390a
`define TGN_GAIN_R4 15'h32d6
`define TGN_GAIN_R5 15'h2d4f

// Oscillator
`define TGN_COEF_FRAC 15
`define TGN_OSC_COS_START 16'h7fff
`define TGN_OSC_SIN_START 16'h0000
`define TGN_SAMPLE_MAX 16'h7fff
`define TGN_SAMPLE_MIN 16'h8000
`define TGN_COUNT_ZERO 24'h000000
`define TGN_COUNT_ONE 24'h000001

`endif

/* File: rtl/tgn_pkg.sv */
// Types shared by the tone generator top and its oscillator.
// Assumes the constants header is available to the including files.
package tgn_pkg;

    typedef struct packed {
        logic [7:0] left_ctl;
        logic [7:0] right_ctl;
        logic [7:0] len_hi;
        logic [7:0] len_mid;
        logic [7:0] len_lo;
        logic [7:0] sin_hi;
        logic [7:0] sin_lo;
        logic [7:0] cos_hi;
        logic [7:0] cos_lo;
    } tgn_regs_t;

    typedef struct packed {
        logic signed [15:0] left;
        logic signed [15:0] right;
        logic valid;
    } tgn_sample_t;

    typedef struct packed {
        logic signed [15:0] sine;
        logic signed [15:0] cosine;
        logic valid;
    } tgn_osc_state_t;

    typedef struct packed {
        tgn_regs_t regs;
        logic [23:0] remaining;
        logic running;
        tgn_sample_t out;
        logic [7:0] rdata;
        logic rvalid;
    } tgn_state_t;

endpackage

/* File: rtl/tgn_osc.sv */
// Two-state recursive sine oscillator: rotates a (sine, cosine) pair by a fixed phase step.
// Assumes coefficients in Q1.15 and a one-cycle advance strobe from the same clock.
`timescale 1ns/100ps
`include "tgn_consts.svh"

module tgn_osc (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Control
    input wire logic restart,
    input wire logic advance,
    input wire logic signed [15:0] sin_coef,
    input wire logic signed [15:0] cos_coef,
    // Result
    output logic signed [15:0] sine,
    output logic sine_valid
);

    tgn_pkg::tgn_osc_state_t st_r;
    tgn_pkg::tgn_osc_state_t st_nxt;

    function automatic logic signed [15:0] clamp(input logic signed [32:0] acc);
        logic signed [32:0] shifted;
        shifted = acc >>> `TGN_COEF_FRAC;
        if (shifted > $signed({17'h00000, `TGN_SAMPLE_MAX})) begin
            clamp = `TGN_SAMPLE_MAX;
        end else if (shifted < $signed({17'h1ffff, `TGN_SAMPLE_MIN})) begin
            clamp = `TGN_SAMPLE_MIN;
        end else begin
            clamp = shifted[15:0];
        end
    endfunction

    always_comb begin
        logic signed [32:0] s_acc;
        logic signed [32:0] c_acc;
        s_acc = 33'(st_r.sine * cos_coef) + 33'(st_r.cosine * sin_coef);
        c_acc = 33'(st_r.cosine * cos_coef) - 33'(st_r.sine * sin_coef);
        st_nxt = st_r;
        st_nxt.valid = 1'b0;
        if (restart) begin
            st_nxt.sine = `TGN_OSC_SIN_START;
            st_nxt.cosine = `TGN_OSC_COS_START;
        end else if (advance) begin
            // Truncation makes the amplitude decay slowly, which keeps the pair from overflowing
            st_nxt.sine = clamp(s_acc);
            st_nxt.cosine = clamp(c_acc);
            st_nxt.valid = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_r <= '{sine: `TGN_OSC_SIN_START, cosine: `TGN_OSC_COS_START, valid: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sine = st_r.sine;
    assign sine_valid = st_r.valid;

endmodule

/* File: rtl/tgn_tone_gen.sv */
// Beep tone generator: control registers, sample counter, volume linking and scaling.
// Assumes a byte-wide register port and a one-cycle DAC sample strobe, both on sys_clk.
`timescale 1ns/100ps
`include "tgn_consts.svh"

// Function
// - Link field 00/11 independent, 01 left takes right volume, 10 right takes left.
// - Right volume code 0 is +2 dB, each step 1 dB lower, down to -61 dB.
// - Tone runs only in the one tone-capable playback block mode.
// - Tone lasts exactly the programmed 24-bit number of DAC sample periods.
// - Length is high, middle, low byte at ascending addresses.
// - Sine and cosine coefficients are 16 bits, high byte then low byte.
// - Enable bit starts the tone; hardware clears it when the count elapses.
// - Left volume uses the same code mapping as the right volume.
// - Auto bit lets a pen touch start a tone while the codec clock runs.
module tgn_tone_gen (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Playback path status
    input wire logic [4:0] dac_proc_mode,
    input wire logic dac_sample_tick,
    // Touch detection
    input wire logic pen_touch,
    input wire logic codec_source_clock_running,
    // Tone output
    output logic signed [15:0] tone_left,
    output logic signed [15:0] tone_right,
    output logic tone_valid,
    output logic tone_active
);

    tgn_pkg::tgn_state_t st_r;
    tgn_pkg::tgn_state_t st_nxt;

    logic signed [15:0] osc_sine;
    logic osc_valid;
    logic osc_restart;
    logic osc_advance;
    logic mode_ok;
    logic [23:0] length;
    logic signed [15:0] sin_coef;
    logic signed [15:0] cos_coef;
    logic [1:0] link;
    logic [5:0] left_code;
    logic [5:0] right_code;
    logic [5:0] eff_left_code;
    logic [5:0] eff_right_code;

    // Code = 6*q + r: one mantissa per dB within a six-step octave, then a shift per octave.
    // Six steps are 6.02 dB, so the highest codes sit up to about 0.2 dB off nominal.
    function automatic logic signed [15:0] scale(input logic signed [15:0] smp,
                                                 input logic [5:0] code);
        logic [5:0] q;
        logic [5:0] r;
        logic [14:0] mant;
        logic signed [32:0] prod;
        logic signed [32:0] shifted;
        q = code / `TGN_STEPS_PER_OCTAVE;
        r = code % `TGN_STEPS_PER_OCTAVE;
        case (r)
            6'h00: mant = `TGN_GAIN_R0;
            6'h01: mant = `TGN_GAIN_R1;
            6'h02: mant = `TGN_GAIN_R2;
            6'h03: mant = `TGN_GAIN_R3;
            6'h04: mant = `TGN_GAIN_R4;
            default: mant = `TGN_GAIN_R5;
        endcase
        prod = 33'(smp * $signed({1'b0, mant}));
        shifted = (prod >>> `TGN_GAIN_FRAC) >>> q;
        // The +2 dB and +1 dB codes can exceed full scale, so saturate
        if (shifted > $signed({17'h00000, `TGN_SAMPLE_MAX})) begin
            scale = `TGN_SAMPLE_MAX;
        end else if (shifted < $signed({17'h1ffff, `TGN_SAMPLE_MIN})) begin
            scale = `TGN_SAMPLE_MIN;
        end else begin
            scale = shifted[15:0];
        end
    endfunction

    assign length = {st_r.regs.len_hi, st_r.regs.len_mid, st_r.regs.len_lo};
    assign sin_coef = {st_r.regs.sin_hi, st_r.regs.sin_lo};
    assign cos_coef = {st_r.regs.cos_hi, st_r.regs.cos_lo};
    assign mode_ok = (dac_proc_mode == `TGN_TONE_CAPABLE_PLAYBACK_BLOCK_MODE);
    assign link = st_r.regs.right_ctl[`TGN_LINK_HI:`TGN_LINK_LO];
    assign left_code = st_r.regs.left_ctl[`TGN_VOL_HI:`TGN_VOL_LO];
    assign right_code = st_r.regs.right_ctl[`TGN_VOL_HI:`TGN_VOL_LO];

    always_comb begin
        eff_left_code = left_code;
        eff_right_code = right_code;
        if (link == `TGN_LINK_LEFT_FROM_RIGHT) begin
            eff_left_code = right_code;
        end else if (link == `TGN_LINK_RIGHT_FROM_LEFT) begin
            eff_right_code = left_code;
        end
    end

    always_comb begin
        logic start;
        logic sw_start;
        logic sw_stop;
        logic touch_start;
        logic finish;
        logic idle;
        start = 1'b0;
        sw_start = 1'b0;
        sw_stop = 1'b0;
        touch_start = 1'b0;
        finish = 1'b0;
        idle = !st_r.running;
        osc_restart = 1'b0;
        osc_advance = 1'b0;
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;
        st_nxt.out.valid = 1'b0;

        // Register writes
        if (reg_wr) begin
            if (reg_addr == `TGN_OFS_LEFT_CTL) begin
                st_nxt.regs.left_ctl = reg_wdata;
                sw_start = reg_wdata[`TGN_BIT_ENABLE] && idle;
                sw_stop = !reg_wdata[`TGN_BIT_ENABLE];
            end else if (reg_addr == `TGN_OFS_RIGHT_CTL) begin
                st_nxt.regs.right_ctl = reg_wdata;
            end else if (reg_addr == `TGN_OFS_LEN_HI) begin
                st_nxt.regs.len_hi = reg_wdata;
            end else if (reg_addr == `TGN_OFS_LEN_MID) begin
                st_nxt.regs.len_mid = reg_wdata;
            end else if (reg_addr == `TGN_OFS_LEN_LO) begin
                st_nxt.regs.len_lo = reg_wdata;
            end else if (reg_addr == `TGN_OFS_SIN_HI) begin
                st_nxt.regs.sin_hi = reg_wdata;
            end else if (reg_addr == `TGN_OFS_SIN_LO) begin
                st_nxt.regs.sin_lo = reg_wdata;
            end else if (reg_addr == `TGN_OFS_COS_HI) begin
                st_nxt.regs.cos_hi = reg_wdata;
            end else if (reg_addr == `TGN_OFS_COS_LO) begin
                st_nxt.regs.cos_lo = reg_wdata;
            end
        end

        // A touch only starts a tone from idle and never during a software write to the enable
        touch_start = idle && st_r.regs.left_ctl[`TGN_BIT_AUTO_TOUCH] && pen_touch
                      && codec_source_clock_running
                      && !(reg_wr && reg_addr == `TGN_OFS_LEFT_CTL);

        // Sample stepping; outside the capable mode the count holds and no sample is made
        if (st_r.running && !sw_stop && dac_sample_tick && mode_ok) begin
            osc_advance = 1'b1;
            st_nxt.remaining = st_r.remaining - `TGN_COUNT_ONE;
            finish = (st_r.remaining == `TGN_COUNT_ONE);
        end

        // A software set in the finishing cycle wins and starts a fresh tone;
        // the old tone's last sample is lost because the oscillator restarts
        sw_start = sw_start || (finish && reg_wr && reg_addr == `TGN_OFS_LEFT_CTL
                   && reg_wdata[`TGN_BIT_ENABLE]);
        start = sw_start || touch_start;

        if (start) begin
            osc_restart = 1'b1;
            st_nxt.remaining = length;
            st_nxt.running = (length != `TGN_COUNT_ZERO);
            st_nxt.regs.left_ctl[`TGN_BIT_ENABLE] = (length != `TGN_COUNT_ZERO);
        end else if (sw_stop) begin
            st_nxt.running = 1'b0;
            st_nxt.remaining = `TGN_COUNT_ZERO;
        end else if (finish) begin
            // Self-clear once the count runs out
            st_nxt.running = 1'b0;
            st_nxt.regs.left_ctl[`TGN_BIT_ENABLE] = 1'b0;
        end

        // Scale each new oscillator sample by the effective per-channel volume
        if (osc_valid) begin
            st_nxt.out.left = scale(osc_sine, eff_left_code);
            st_nxt.out.right = scale(osc_sine, eff_right_code);
            st_nxt.out.valid = 1'b1;
        end else if (!st_r.running) begin
            st_nxt.out.left = 16'h0000;
            st_nxt.out.right = 16'h0000;
        end

        // Register reads, answered one cycle later; unmapped offsets read as zero
        if (reg_rd) begin
            st_nxt.rvalid = 1'b1;
            if (reg_addr == `TGN_OFS_LEFT_CTL) begin
                st_nxt.rdata = st_r.regs.left_ctl;
            end else if (reg_addr == `TGN_OFS_RIGHT_CTL) begin
                st_nxt.rdata = st_r.regs.right_ctl;
            end else if (reg_addr == `TGN_OFS_LEN_HI) begin
                st_nxt.rdata = st_r.regs.len_hi;
            end else if (reg_addr == `TGN_OFS_LEN_MID) begin
                st_nxt.rdata = st_r.regs.len_mid;
            end else if (reg_addr == `TGN_OFS_LEN_LO) begin
                st_nxt.rdata = st_r.regs.len_lo;
            end else if (reg_addr == `TGN_OFS_SIN_HI) begin
                st_nxt.rdata = st_r.regs.sin_hi;
            end else if (reg_addr == `TGN_OFS_SIN_LO) begin
                st_nxt.rdata = st_r.regs.sin_lo;
            end else if (reg_addr == `TGN_OFS_COS_HI) begin
                st_nxt.rdata = st_r.regs.cos_hi;
            end else if (reg_addr == `TGN_OFS_COS_LO) begin
                st_nxt.rdata = st_r.regs.cos_lo;
            end else begin
                st_nxt.rdata = `TGN_RST_ZERO8;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_r.regs.left_ctl <= `TGN_RST_LEFT_CTL;
            st_r.regs.right_ctl <= `TGN_RST_RIGHT_CTL;
            st_r.regs.len_hi <= `TGN_RST_LEN_HI;
            st_r.regs.len_mid <= `TGN_RST_LEN_MID;
            st_r.regs.len_lo <= `TGN_RST_LEN_LO;
            st_r.regs.sin_hi <= `TGN_RST_SIN_HI;
            st_r.regs.sin_lo <= `TGN_RST_SIN_LO;
            st_r.regs.cos_hi <= `TGN_RST_COS_HI;
            st_r.regs.cos_lo <= `TGN_RST_COS_LO;
            st_r.remaining <= `TGN_COUNT_ZERO;
            st_r.running <= 1'b0;
            st_r.out <= '0;
            st_r.rdata <= `TGN_RST_ZERO8;
            st_r.rvalid <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Coefficients follow the registers live, so software loads them before starting a tone
    tgn_osc u_osc (
        .sys_clk(sys_clk),
        .srst(srst),
        .restart(osc_restart),
        .advance(osc_advance),
        .sin_coef(sin_coef),
        .cos_coef(cos_coef),
        .sine(osc_sine),
        .sine_valid(osc_valid)
    );

    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign tone_left = st_r.out.left;
    assign tone_right = st_r.out.right;
    assign tone_valid = st_r.out.valid;
    assign tone_active = st_r.running;

endmodule

/* File: sim/tgn_tone_gen_chk.sv */
// Concurrent checks on the tone generator ports, bound to every tgn_tone_gen.
// Assumes the constants header on the include path and one clock domain.
`timescale 1ns/100ps
`include "tgn_consts.svh"

module tgn_tone_gen_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // Playback path and touch
    input wire logic [4:0] dac_proc_mode,
    input wire logic dac_sample_tick,
    input wire logic pen_touch,
    input wire logic codec_source_clock_running,
    // Tone output
    input wire logic signed [15:0] tone_left,
    input wire logic signed [15:0] tone_right,
    input wire logic tone_valid,
    input wire logic tone_active
);
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (srst);

    read_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read strobe got no answer");
    no_stray_answer_a: assert property (!reg_rd |=> !reg_rvalid)
        else $error("answer without a read");
    rdata_hold_a: assert property (!reg_rvalid |-> $stable(reg_rdata))
        else $error("read data moved without an answer");
    unmapped_zero_a: assert property (reg_rd && (reg_addr < 8'h47 || reg_addr > 8'h4f)
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    sample_cause_a: assert property (tone_valid |->
        $past(dac_sample_tick, 2) && $past(tone_active, 2)
        && $past(dac_proc_mode, 2) == `TGN_TONE_CAPABLE_PLAYBACK_BLOCK_MODE)
        else $error("sample without a counted tick");
    tick_sample_a: assert property (dac_sample_tick && tone_active && !reg_wr
        && dac_proc_mode == `TGN_TONE_CAPABLE_PLAYBACK_BLOCK_MODE ##1 !reg_wr |-> ##1 tone_valid)
        else $error("counted tick gave no sample");
    start_cause_a: assert property ($rose(tone_active) |->
        ($past(reg_wr) && $past(reg_addr) == 8'h47 && $past(reg_wdata) >= 8'h80)
        || ($past(pen_touch) && $past(codec_source_clock_running)))
        else $error("tone started without cause");
    stop_write_a: assert property (reg_wr && reg_addr == 8'h47 && !reg_wdata[7]
        |=> !tone_active)
        else $error("enable clear did not stop");
    end_cause_a: assert property ($fell(tone_active) |->
        $past(dac_sample_tick) || $past(reg_wr))
        else $error("tone ended without tick or write");
    pause_hold_a: assert property (tone_active && !reg_wr && !(dac_sample_tick
        && dac_proc_mode == `TGN_TONE_CAPABLE_PLAYBACK_BLOCK_MODE) |=> tone_active)
        else $error("tone ended on an uncounted cycle");
endmodule

bind tgn_tone_gen tgn_tone_gen_chk u_chk (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .dac_proc_mode(dac_proc_mode), .dac_sample_tick(dac_sample_tick),
    .pen_touch(pen_touch), .codec_source_clock_running(codec_source_clock_running),
    .tone_left(tone_left), .tone_right(tone_right), .tone_valid(tone_valid),
    .tone_active(tone_active));

/* File: sim/tgn_dac_model.sv */
// Playback DAC side: issues sample strobes at a bench-chosen spacing and collects samples.
// Assumes the same clock as the tone generator; strobes change on the falling edge.
`timescale 1ns/100ps

module tgn_dac_model (
    // Clock
    input wire logic sys_clk,
    // Bench control
    input wire logic run,
    input wire logic [3:0] gap,
    input wire logic clr,
    // Samples from the tone generator
    input wire logic signed [15:0] tone_left,
    input wire logic signed [15:0] tone_right,
    input wire logic tone_valid,
    // Strobe and observations
    output logic dac_sample_tick,
    output int sample_count,
    output logic signed [15:0] first_left,
    output logic signed [15:0] first_right
);
    int phase;

    initial begin
        dac_sample_tick = 1'b0;
        sample_count = 0;
        phase = 0;
        first_left = 16'h0000;
        first_right = 16'h0000;
    end

    // Strobe is one cycle wide, spacing gap+1 cycles
    always @(negedge sys_clk) begin
        if (run && phase >= int'(gap)) begin
            dac_sample_tick = 1'b1;
            phase = 0;
        end else begin
            dac_sample_tick = 1'b0;
            phase++;
        end
    end

    always @(posedge sys_clk) begin
        if (clr) begin
            sample_count <= 0;
        end else if (tone_valid === 1'b1) begin
            if (sample_count == 0) begin
                first_left <= tone_left;
                first_right <= tone_right;
            end
            sample_count <= sample_count + 1;
        end
    end
endmodule

/* File: sim/tgn_tone_gen_tb_top.sv */
// Self-checking bench: register map, tone runs with linking, pause, stop, touch start, reset.
// Assumes the DAC model in sim/ and the checker bound onto the design.
`timescale 1ns/100ps
`include "tgn_consts.svh"

module tgn_tone_gen_tb_top;
    logic sys_clk, srst, reg_wr, reg_rd, pen_touch, clk_run, run, clr, reg_rvalid;
    logic tone_valid, tone_active, tick;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic [4:0] mode;
    logic [3:0] gap;
    logic signed [15:0] tone_left, tone_right, first_left, first_right;
    logic [31:0] seed;
    logic [7:0] addrs [11] = '{8'h46, 8'h47, 8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h4e,
        8'h4f, 8'h50};
    logic [7:0] rstv [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hee, 8'h10, 8'hd8, 8'h7e,
        8'he3, 8'h00};
    int sample_count, mismatches, total_checks;

    tgn_tone_gen u_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .dac_proc_mode(mode), .dac_sample_tick(tick),
        .pen_touch(pen_touch), .codec_source_clock_running(clk_run), .tone_left(tone_left),
        .tone_right(tone_right), .tone_valid(tone_valid), .tone_active(tone_active));
    tgn_dac_model u_dac (.sys_clk(sys_clk), .run(run), .gap(gap), .clr(clr),
        .tone_left(tone_left), .tone_right(tone_right), .tone_valid(tone_valid),
        .dac_sample_tick(tick), .sample_count(sample_count), .first_left(first_left),
        .first_right(first_right));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // First sample after start: one rotation of (0, full scale), then gain for codes 6k+2
    function automatic logic [15:0] exp_first(input logic [15:0] sn, input logic [5:0] code);
        int v;
        v = (int'(`TGN_OSC_COS_START) * int'($signed(sn))) >>> `TGN_COEF_FRAC;
        v = (v * int'(`TGN_GAIN_R2)) >>> (`TGN_GAIN_FRAC + int'(code) / 6);
        return 16'(v);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask

    task automatic do_reset(input int n);
        srst = 1'b1;
        repeat (n) @(negedge sys_clk);
        srst = 1'b0;
    endtask

    task automatic run_tone(input logic [23:0] len, input logic [1:0] link,
        input logic [5:0] lc, input logic [5:0] rc);
        logic [15:0] sn;
        logic [5:0] el, er;
        seed = lfsr(seed);
        sn = {1'b0, seed[14:0]} | 16'h0100;
        gap = 4'(seed[18:16]) + 4'h1;
        el = (link == 2'b01) ? rc : lc;
        er = (link == 2'b10) ? lc : rc;
        wr(8'h4c, sn[15:8]);
        wr(8'h4d, sn[7:0]);
        wr(8'h49, len[23:16]);
        wr(8'h4a, len[15:8]);
        wr(8'h4b, len[7:0]);
        wr(8'h48, {link, rc});
        clr = 1'b1;
        @(negedge sys_clk);
        clr = 1'b0;
        wr(8'h47, {2'b10, lc});
        repeat (6) @(negedge sys_clk);
        if (len > 24'd8) begin
            mode = (seed[4:0] == 5'h19) ? 5'h18 : seed[4:0];
            // A second start while running must not restart the count
            wr(8'h47, {2'b10, lc});
            repeat (12) @(negedge sys_clk);
            check({15'h0000, tone_active}, 16'h0001);
            mode = 5'h19;
        end
        for (int i = 0; i < 4000 && tone_active !== 1'b0; i++) @(negedge sys_clk);
        repeat (4) @(negedge sys_clk);
        check({15'h0000, tone_active}, 16'h0000);
        check(tone_left, 16'h0000);
        check(tone_right, 16'h0000);
        check(16'(sample_count), len[15:0]);
        check(first_left, exp_first(sn, el));
        check(first_right, exp_first(sn, er));
        rd(8'h47, rv);
        check({8'h00, rv}, {10'h000, lc});
        $display("test tone len %0d link %0d done", len, link);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial begin
        #2000000;
        mismatches++;
        give_verdict();
    end

    initial begin
        {srst, reg_wr, reg_rd, pen_touch, clk_run, run, clr} = 7'h00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        mode = 5'h19;
        gap = 4'h3;
        seed = 32'ha827;
        mismatches = 0;
        total_checks = 0;
        do_reset(16);
        for (int i = 0; i < 11; i++) begin
            rd(addrs[i], rv);
            check({8'h00, rv}, {8'h00, rstv[i]});
        end
        $display("test reset values done");
        for (int i = 0; i < 11; i++) begin
            seed = lfsr(seed);
            wr(addrs[i], (i == 1) ? (seed[7:0] & 8'h3f) : seed[7:0]);
            rd(addrs[i], rv);
            check({8'h00, rv}, (i == 0 || i == 10) ? 16'h0000 : ((i == 1) ? {8'h00,
                seed[7:0] & 8'h3f} : {8'h00, seed[7:0]}));
        end
        $display("test register access done");
        run = 1'b1;
        run_tone(24'd3, 2'b00, 6'd2, 6'd8);
        run_tone(24'd1, 2'b01, 6'd20, 6'd14);
        run_tone(24'd258, 2'b10, 6'd8, 6'd26);
        run_tone(24'd9, 2'b11, 6'd14, 6'd2);
        wr(8'h49, 8'h00);
        wr(8'h4a, 8'h00);
        wr(8'h4b, 8'h00);
        wr(8'h47, 8'h82);
        @(negedge sys_clk);
        check({15'h0000, tone_active}, 16'h0000);
        rd(8'h47, rv);
        check({8'h00, rv}, 16'h0002);
        wr(8'h4b, 8'hff);
        wr(8'h47, 8'h82);
        repeat (8) @(negedge sys_clk);
        wr(8'h47, 8'h02);
        check({15'h0000, tone_active}, 16'h0000);
        $display("test zero length and stop done");
        wr(8'h47, 8'h42);
        for (int c = 0; c < 2; c++) begin
            clk_run = 1'(c);
            pen_touch = 1'b1;
            @(negedge sys_clk);
            pen_touch = 1'b0;
            repeat (3) @(negedge sys_clk);
            check({15'h0000, tone_active}, 16'(c));
        end
        do_reset(2);
        check({15'h0000, tone_active}, 16'h0000);
        rd(8'h4b, rv);
        check({8'h00, rv}, 16'h00ee);
        $display("test touch start and reset done");
        give_verdict();
    end
endmodule
